// ### rtl/spi_host_client_core.sv
/*
 * Serial port core working as host or client, with an AXI4-Lite register port.
 * Assumes pins arrive asynchronously and a 25 MHz system clock.
 */
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
// Operation
// - full duplex byte exchange on clock, two data lines and a select line
// - software picks host or client; the host drives every transaction
// - bit order selectable, least or most significant bit first
// - host offers seven serial clock rates derived from the system clock
// - double speed lets the serial clock reach half the system clock
// - one 8-bit shift register shifts one bit out and in per step
// - data write loads shift register unbuffered, transmit buffer when buffered
// - data read returns receive register unbuffered, receive buffer when buffered
// - host generates the serial clock itself and drives it out
// - client synchronises incoming serial clock and steps on its edges
// - host pulls select low, then clocks the prepared data across
// - host to client data on mosi, client to host on miso
// - pins set as output are driven by the port logic
// - when enabled, role inputs are forced to input regardless of direction
// - client drives miso only while select is low
// - flag raised when a byte transfer ends
// - data write during a transfer sets the write collision flag; when buffered, only a write to a full transmit buffer does
// - a set done flag raises a wake request one cycle later
// - in host mode a data write that does not collide starts a new byte
// - host with select input low drops to client and sets done flag
// - client select high halts shifting and discards a partial byte
`timescale 1ns/1ps
module spi_host_client_core
	import spi_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic ss_n_in,
	output logic ss_n_out,
	output logic ss_n_oe,
	output logic wake_req
);
	logic [5:0] ctrl_a;
	logic [1:0] ctrl_b;
	logic [3:0] pin_dir;
	logic done_flag, write_collision_flag;
	logic [7:0] aw_addr, w_data;
	logic aw_held, w_held, w_lane0;
	logic mosi_m, mosi_s, miso_m, miso_s, sck_m, sck_s, sck_d, ss_m, ss_s;
	logic [7:0] sr, tx_buf, rx_byte, rx_q0, rx_q1, host_rx;
	logic [3:0] bit_cnt, samp_cnt;
	logic [2:0] samp_pipe;
	logic [1:0] rx_cnt;
	logic xfer_on, sck_q, mosi_q, miso_q, tx_full, byte_done, tick, host_full, host_end;

	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		return lsb ? v[0] : v[7];
	endfunction : out_bit

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
		return lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	wire enable = ctrl_a[CA_ENABLE];
	wire host = ctrl_a[CA_HOST];
	wire lsb = ctrl_a[CA_LSB_FIRST];
	wire buffered = ctrl_b[CB_BUFFERED];
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire data_wr = do_write && aw_addr == DATA_ADDR && w_lane0;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire pop = rd_take && s_axi_araddr == DATA_ADDR && buffered && rx_cnt != 2'h0;
	wire sck_rise = sck_s && !sck_d;
	wire sck_fall = !sck_s && sck_d;
	wire busy = host ? xfer_on : (!ss_s && bit_cnt != 4'h0);
	wire collide = enable && data_wr && (buffered ? tx_full : busy);
	wire mode_drop = enable && host && !ctrl_b[CB_SELECT_IGNORE] && !pin_dir[PD_SS] && !ss_s;
	wire load_now = enable && !busy && (buffered ? tx_full : data_wr);
	wire [7:0] load_val = buffered ? tx_buf : w_data;
	wire [7:0] shifted = shift_in(sr, host ? miso_s : mosi_s, lsb);
	wire [7:0] host_shifted = shift_in(host_rx, miso_s, lsb);
	wire rx_push = byte_done && buffered && (rx_cnt != RX_DEPTH || pop);
	wire [1:0] fill_at = rx_cnt - {1'b0, pop};

	// pins cross into the clock domain through two flops
	always_ff @(posedge clk) begin
		{mosi_s, mosi_m} <= {mosi_m, mosi_in};
		{miso_s, miso_m} <= {miso_m, miso_in};
		{sck_d, sck_s, sck_m} <= {sck_s, sck_m, sck_in};
		{ss_s, ss_m} <= {ss_m, ss_n_in};
	end

	spi_rate_gen u_rate (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(enable && host && xfer_on),
		.rate(ctrl_a[CA_RATE_LO+1:CA_RATE_LO]),
		.double_speed(ctrl_a[CA_DOUBLE]),
		.tick(tick)
	);

	// write address and data are taken in either order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{aw_held, w_held, w_lane0} <= 3'h0;
			{aw_addr, w_data} <= 16'h0000;
			{s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'h0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] <= PIN_DIR_ADDR[7:2] && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read answer; a buffered data read pops the receive queue
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{s_axi_arready, s_axi_rvalid} <= 2'h0;
			{s_axi_rdata, s_axi_rresp} <= {32'h0000_0000, RESP_OKAY};
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				CTRL_A_ADDR: s_axi_rdata <= {26'h0, ctrl_a};
				CTRL_B_ADDR: s_axi_rdata <= {30'h0, ctrl_b};
				FLAGS_ADDR: s_axi_rdata <= {28'h0, busy, buffered ? !tx_full : !busy, write_collision_flag, done_flag};
				DATA_ADDR: s_axi_rdata <= {24'h0, rx_q0};
				PIN_DIR_ADDR: s_axi_rdata <= {28'h0, pin_dir};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// control registers; a select pulled low takes the host role away
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{ctrl_a, ctrl_b, pin_dir} <= {CTRL_A_RESET, CTRL_B_RESET, PIN_DIR_RESET};
		end else begin
			if (do_write && w_lane0 && aw_addr == CTRL_A_ADDR)
				ctrl_a <= w_data[5:0];
			if (do_write && w_lane0 && aw_addr == CTRL_B_ADDR)
				ctrl_b <= w_data[1:0];
			if (do_write && w_lane0 && aw_addr == PIN_DIR_ADDR)
				pin_dir <= w_data[3:0];
			if (mode_drop)
				ctrl_a[CA_HOST] <= 1'b0;
		end
	end

	// sticky flags, write one to clear, a new event wins over the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{done_flag, write_collision_flag, wake_req} <= 3'h0;
		end else begin
			if (do_write && w_lane0 && aw_addr == FLAGS_ADDR && w_data[FL_DONE])
				done_flag <= 1'b0;
			if (do_write && w_lane0 && aw_addr == FLAGS_ADDR && w_data[FL_COLLISION])
				write_collision_flag <= 1'b0;
			if (byte_done || mode_drop)
				done_flag <= 1'b1;
			if (collide)
				write_collision_flag <= 1'b1;
			wake_req <= done_flag;
		end
	end

	// shift engine shared by host and client
	always_ff @(posedge clk) begin
		byte_done <= 1'b0;
		if (sys_rst || !enable) begin
			{sr, tx_buf, rx_byte, host_rx} <= 32'h0000_0000;
			{bit_cnt, samp_cnt, samp_pipe} <= 11'h000;
			{xfer_on, sck_q, mosi_q, miso_q, tx_full, host_full, host_end} <= 7'h00;
		end else if (mode_drop) begin
			{xfer_on, sck_q, host_full, host_end} <= 4'h0;
			{bit_cnt, samp_cnt, samp_pipe} <= 11'h000;
		end else begin
			if (load_now) begin
				sr <= load_val;
				mosi_q <= out_bit(load_val, lsb);
				miso_q <= out_bit(load_val, lsb);
				if (host) begin
					xfer_on <= 1'b1;
					bit_cnt <= 4'h0;
				end
			end else if (host && xfer_on && tick) begin
				if (!sck_q) begin
					sck_q <= 1'b1;
					sr <= shifted;
					bit_cnt <= bit_cnt + 4'h1;
				end else begin
					sck_q <= 1'b0;
					if (bit_cnt == BITS_PER_BYTE) begin
						xfer_on <= 1'b0;
						host_end <= 1'b1;
					end else begin
						mosi_q <= out_bit(sr, lsb);
					end
				end
			end else if (!host) begin
				// relies on each clock phase lasting over two system clocks
				if (ss_s) begin
					bit_cnt <= 4'h0;
				end else if (sck_rise) begin
					sr <= shifted;
					if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
						bit_cnt <= 4'h0;
						byte_done <= 1'b1;
						rx_byte <= shifted;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end else if (sck_fall) begin
					miso_q <= out_bit(sr, lsb);
				end
			end
			if (buffered && data_wr && !tx_full) begin
				tx_buf <= w_data;
				tx_full <= 1'b1;
			end else if (buffered && load_now) begin
				tx_full <= 1'b0;
			end
			// miso returns through the pin synchroniser: sample three cycles after each rise
			samp_pipe <= {samp_pipe[1:0], host && xfer_on && tick && !sck_q};
			if (host && samp_pipe[2]) begin
				host_rx <= host_shifted;
				samp_cnt <= (samp_cnt == BITS_PER_BYTE - 4'h1) ? 4'h0 : samp_cnt + 4'h1;
				if (samp_cnt == BITS_PER_BYTE - 4'h1) begin
					rx_byte <= host_shifted;
					host_full <= 1'b1;
				end
			end
			if (host && host_full && host_end) begin
				byte_done <= 1'b1;
				{host_full, host_end} <= 2'h0;
			end
		end
	end

	// receive side: single register unbuffered, two-entry queue buffered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{rx_q0, rx_q1, rx_cnt} <= 18'h00000;
		end else if (!buffered) begin
			if (byte_done) begin
				rx_q0 <= rx_byte;
				rx_cnt <= 2'h1;
			end
		end else begin
			if (pop)
				rx_q0 <= rx_q1;
			if (rx_push && fill_at == 2'h0)
				rx_q0 <= rx_byte;
			if (rx_push && fill_at != 2'h0)
				rx_q1 <= rx_byte;
			rx_cnt <= rx_cnt + {1'b0, rx_push} - {1'b0, pop};
		end
	end

	// pin drive; role inputs never driven while enabled
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{mosi_out, miso_out, sck_out, ss_n_out} <= 4'h1;
			{mosi_oe, miso_oe, sck_oe, ss_n_oe} <= 4'h0;
		end else begin
			mosi_out <= mosi_q;
			miso_out <= miso_q;
			sck_out <= sck_q;
			ss_n_out <= !xfer_on;
			mosi_oe <= enable && host && pin_dir[PD_MOSI];
			sck_oe <= enable && host && pin_dir[PD_SCK];
			ss_n_oe <= enable && host && pin_dir[PD_SS];
			miso_oe <= enable && !host && pin_dir[PD_MISO] && !ss_s;
		end
	end

	sequence s_host_write;
		enable && host && !mode_drop && data_wr && !buffered && !busy;
	endsequence

	property p_write_starts;
		@(posedge clk) disable iff (sys_rst) s_host_write |=> xfer_on ##1 !ss_n_out;
	endproperty
	a_write_starts: assert property (p_write_starts) else $error("host write did not start a byte");

	property p_drop_to_client;
		@(posedge clk) disable iff (sys_rst) mode_drop |=> !ctrl_a[CA_HOST] && done_flag && !xfer_on;
	endproperty
	a_drop_to_client: assert property (p_drop_to_client) else $error("select low did not drop host role");

	property p_miso_released;
		@(posedge clk) disable iff (sys_rst) (!host && ss_s) |=> !miso_oe;
	endproperty
	a_miso_released: assert property (p_miso_released) else $error("miso driven while deselected");

	property p_client_inputs;
		@(posedge clk) disable iff (sys_rst) (enable && !host) |=> !sck_oe && !mosi_oe && !ss_n_oe;
	endproperty
	a_client_inputs: assert property (p_client_inputs) else $error("client drove an input pin");

	property p_collision;
		@(posedge clk) disable iff (sys_rst) collide |=> write_collision_flag;
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged");

	property p_done_flag;
		@(posedge clk) disable iff (sys_rst) byte_done |=> done_flag ##1 wake_req;
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("byte end not flagged");

	property p_partial_dropped;
		@(posedge clk) disable iff (sys_rst) (enable && !host && ss_s) |=> bit_cnt == 4'h0;
	endproperty
	a_partial_dropped: assert property (p_partial_dropped) else $error("partial byte kept");

	property p_client_step;
		@(posedge clk) disable iff (sys_rst)
			(enable && !host && !ss_s && sck_rise && !load_now && bit_cnt < 4'h7) |=> bit_cnt == $past(bit_cnt) + 4'h1;
	endproperty
	a_client_step: assert property (p_client_step) else $error("client edge did not step");
endmodule : spi_host_client_core

// ### rtl/spi_pkg.sv
/*
 * Shared constants for the serial port core: register map, field positions,
 * reset values, clock rate table and bus answer codes.
 * Assumes a single 25 MHz system clock and an AXI4-Lite register master.
 */
package spi_pkg;
	localparam logic [7:0] CTRL_A_ADDR = 8'h00;
	localparam logic [7:0] CTRL_B_ADDR = 8'h04;
	localparam logic [7:0] FLAGS_ADDR = 8'h08;
	localparam logic [7:0] DATA_ADDR = 8'h0C;
	localparam logic [7:0] PIN_DIR_ADDR = 8'h10;

	// control a fields
	localparam int CA_ENABLE = 0;
	localparam int CA_HOST = 1;
	localparam int CA_LSB_FIRST = 2;
	localparam int CA_DOUBLE = 3;
	localparam int CA_RATE_LO = 4;
	localparam logic [5:0] CTRL_A_RESET = 6'h00;
	// control b fields
	localparam int CB_BUFFERED = 0;
	localparam int CB_SELECT_IGNORE = 1;
	localparam logic [1:0] CTRL_B_RESET = 2'h0;
	// flag fields
	localparam int FL_DONE = 0;
	localparam int FL_COLLISION = 1;
	localparam int FL_TX_EMPTY = 2;
	localparam int FL_BUSY = 3;
	// pin direction fields
	localparam int PD_MOSI = 0;
	localparam int PD_MISO = 1;
	localparam int PD_SCK = 2;
	localparam int PD_SS = 3;
	localparam logic [3:0] PIN_DIR_RESET = 4'h0;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] RX_DEPTH = 2'h2;

	// half periods of the serial clock, in system clocks
	localparam logic [6:0] HALF_DIV4 = 7'h02;
	localparam logic [6:0] HALF_DIV16 = 7'h08;
	localparam logic [6:0] HALF_DIV64 = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	localparam logic [6:0] HALF_DIV2 = 7'h01;
	localparam logic [6:0] HALF_DIV8 = 7'h04;
	localparam logic [6:0] HALF_DIV32 = 7'h10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spi_pkg

// ### rtl/spi_rate_gen.sv
/*
 * Serial clock rate generator: one-cycle tick per half period of the host
 * serial clock. Assumes run drops between transfers to realign the phase.
 */
`timescale 1ns/1ps
module spi_rate_gen
	import spi_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [1:0] rate,
	input wire logic double_speed,
	output logic tick
);
	logic [6:0] count;

	function automatic logic [6:0] half_count(input logic [1:0] r, input logic dbl);
		logic [6:0] h;
		h = HALF_DIV4;
		unique case (r)
			2'h0: h = dbl ? HALF_DIV2 : HALF_DIV4;
			2'h1: h = dbl ? HALF_DIV8 : HALF_DIV16;
			2'h2: h = dbl ? HALF_DIV32 : HALF_DIV64;
			2'h3: h = dbl ? HALF_DIV64 : HALF_DIV128;
		endcase
		return h;
	endfunction : half_count

	// seven distinct rates; double speed reaches half the system clock
	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			count <= 7'h00;
			tick <= 1'b0;
		end else if (count + 7'h01 >= half_count(rate, double_speed)) begin
			count <= 7'h00;
			tick <= 1'b1;
		end else begin
			count <= count + 7'h01;
			tick <= 1'b0;
		end
	end
endmodule : spi_rate_gen

// ### verification/spi_peer_model.sv
/*
 * Far-side serial device: answers as client while the core is host and
 * plays host on demand (host_send) while the core is client.
 * Assumes the bench resolves each pin from the core's output enables.
 */
`timescale 1ns/1ps
module spi_peer_model (
	input wire logic clk,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic lsb_first,
	output logic miso_drv,
	output logic sck_drv,
	output logic ss_n_drv,
	output logic mosi_drv
);
	logic [7:0] reply = 8'h00;
	logic [7:0] got = 8'h00;
	logic as_host = 1'b0;
	int nb = 0;
	int nbytes = 0;

	function automatic logic pick(input logic [7:0] v, input int i);
		return lsb_first ? v[i] : v[7 - i];
	endfunction : pick

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
		return lsb_first ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	initial begin
		{sck_drv, ss_n_drv, mosi_drv, miso_drv} = 4'h5;
	end

	// client role: mode 0, first bit ready at select
	always @(negedge ss_n) if (!as_host) begin
		nb = 0;
		miso_drv = pick(reply, 0);
	end
	always @(posedge sck) if (!as_host && !ss_n) begin
		got = shift_in(got, mosi);
		nb++;
		if (nb % 8 == 0) nbytes++;
	end
	always @(negedge sck) if (!as_host && !ss_n) miso_drv = pick(reply, nb % 8);
	// released line shows the inverse of its last bit
	always @(posedge ss_n) if (!as_host) miso_drv = ~miso_drv;

	// host role: select, then mode 0 clocking, clock still outside frames
	task automatic host_send(input logic [7:0] d, input int nbits, input int half);
		as_host = 1'b1;
		ss_n_drv <= 1'b0;
		mosi_drv <= pick(d, 0);
		repeat (half) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			sck_drv <= 1'b1;
			got <= shift_in(got, miso);
			repeat (half) @(posedge clk);
			sck_drv <= 1'b0;
			mosi_drv <= pick(d, (i + 1) % 8);
			repeat (half) @(posedge clk);
		end
		ss_n_drv <= 1'b1;
		mosi_drv <= ~mosi_drv;
		repeat (half) @(posedge clk);
		as_host = 1'b0;
	endtask : host_send
endmodule : spi_peer_model

// ### verification/tb_spi_host_client_core.sv
/*
 * Self-checking bench for the serial port core: registers, host and client
 * exchange, collision, buffering, select handling and partial frames.
 * Assumes the peer model on the pins and a board pull-up on the select line.
 */
`timescale 1ns/1ps
`define check(nm, a, b) begin tests_run++; if ((b) !== (a)) begin errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, a, b); end end
module tb_spi_host_client_core
	import spi_pkg::*;
;
	logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, ss_low, lsb;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awready, wready, bvalid, arready, rvalid, wake_req;
	logic [1:0] bresp, rresp;
	logic mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe, ss_n_out, ss_n_oe;
	logic p_miso, p_sck, p_ss_n, p_mosi, mosi_w, miso_w, sck_w, ss_n_w, sck_prev;
	int errors = 0;
	int tests_run = 0;
	int cnt = 0;
	int last_half = 0;

	assign mosi_w = mosi_oe ? mosi_out : p_mosi;
	assign miso_w = miso_oe ? miso_out : p_miso;
	assign sck_w = sck_oe ? sck_out : p_sck;
	assign ss_n_w = ss_n_oe ? ss_n_out : (p_ss_n & ~ss_low);

	spi_host_client_core uut (
		.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mosi_in(mosi_w), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe(sck_oe), .ss_n_in(ss_n_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe),
		.wake_req(wake_req)
	);

	spi_peer_model peer (
		.clk(clk), .sck(sck_w), .ss_n(ss_n_w), .mosi(mosi_w), .miso(miso_w), .lsb_first(lsb),
		.miso_drv(p_miso), .sck_drv(p_sck), .ss_n_drv(p_ss_n), .mosi_drv(p_mosi)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// cycles between serial clock edges
	always @(posedge clk) begin
		sck_prev <= sck_out;
		cnt <= (sck_out != sck_prev) ? 1 : cnt + 1;
		if (sck_out != sck_prev) last_half <= cnt;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		{awvalid, wvalid, bready} <= 3'h7;
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic wait_done();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 500; i++) begin
			rd(FLAGS_ADDR, d, r);
			if (d[FL_DONE] === 1'b1) break;
		end
		`check("done", 1'b1, d[FL_DONE])
		`check("wake", 1'b1, wake_req)
		wr(FLAGS_ADDR, 8'h01, r);
	endtask : wait_done

	function automatic int exp_half(input logic [1:0] rt, input logic dbl);
		case (rt)
			2'h0: return int'(dbl ? HALF_DIV2 : HALF_DIV4);
			2'h1: return int'(dbl ? HALF_DIV8 : HALF_DIV16);
			2'h2: return int'(dbl ? HALF_DIV32 : HALF_DIV64);
			default: return int'(dbl ? HALF_DIV64 : HALF_DIV128);
		endcase
	endfunction : exp_half

	task end_sim;
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		#(40 * 90000);
		errors++;
		$display("watchdog expired");
		end_sim();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] tx, rx;
		logic b;
		int nb0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, ss_low, lsb} = '0;
		sys_rst = 1'b1;
		void'($urandom(88));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rd(CTRL_A_ADDR, d, r);
		`check("ctrl_a reset", {26'h0, CTRL_A_RESET}, d)
		rd(PIN_DIR_ADDR, d, r);
		`check("pin_dir reset", {28'h0, PIN_DIR_RESET}, d)
		rd(8'h14, d, r);
		`check("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
		wr(8'h14, 8'hA5, r);
		`check("unmapped write", RESP_SLVERR, r)
		$display("test registers done");
		wr(PIN_DIR_ADDR, 8'h0D, r);
		for (int k = 0; k < 8; k++) begin
			b = 1'($urandom_range(1, 0));
			lsb <= b;
			tx = 8'($urandom);
			rx = 8'($urandom);
			peer.reply = rx;
			wr(CTRL_A_ADDR, {2'h0, k[1:0], k[2], b, 2'h3}, r);
			wr(DATA_ADDR, tx, r);
			@(posedge clk);
			`check("select low", 1'b0, ss_n_w)
			`check("clock driven", 1'b1, sck_oe)
			wait_done();
			rd(DATA_ADDR, d, r);
			`check("host rx", {24'h0, rx}, d)
			`check("peer rx", tx, peer.got)
			`check("half period", exp_half(k[1:0], k[2]), last_half)
			`check("select high", 1'b1, ss_n_w)
		end
		$display("test host rates done");
		lsb <= 1'b0;
		wr(CTRL_A_ADDR, 8'h33, r);
		tx = 8'($urandom);
		wr(DATA_ADDR, tx, r);
		wr(DATA_ADDR, ~tx, r);
		rd(FLAGS_ADDR, d, r);
		`check("collision", 1'b1, d[FL_COLLISION])
		wait_done();
		`check("first byte kept", tx, peer.got)
		wr(FLAGS_ADDR, 8'h02, r);
		rd(FLAGS_ADDR, d, r);
		`check("collision clear", 1'b0, d[FL_COLLISION])
		$display("test collision done");
		wr(CTRL_B_ADDR, 8'h01, r);
		wr(CTRL_A_ADDR, 8'h03, r);
		nb0 = peer.nbytes;
		wr(DATA_ADDR, 8'h3C, r);
		wr(DATA_ADDR, 8'hC3, r);
		rd(FLAGS_ADDR, d, r);
		`check("buffered write", 1'b0, d[FL_COLLISION])
		for (int i = 0; i < 200 && !(d[FL_BUSY] === 1'b0 && d[FL_TX_EMPTY] === 1'b1); i++) rd(FLAGS_ADDR, d, r);
		`check("bytes sent", nb0 + 2, peer.nbytes)
		`check("last byte", 8'hC3, peer.got)
		rd(DATA_ADDR, d, r);
		`check("queue first", {24'h0, rx}, d)
		rd(DATA_ADDR, d, r);
		`check("queue second", {24'h0, rx}, d)
		wr(FLAGS_ADDR, 8'h03, r);
		wr(CTRL_B_ADDR, 8'h00, r);
		$display("test buffered done");
		wr(PIN_DIR_ADDR, 8'h05, r);
		ss_low <= 1'b1;
		repeat (8) @(posedge clk);
		ss_low <= 1'b0;
		rd(CTRL_A_ADDR, d, r);
		`check("host dropped", 1'b0, d[CA_HOST])
		wait_done();
		wr(CTRL_B_ADDR, 8'h02, r);
		wr(CTRL_A_ADDR, 8'h03, r);
		ss_low <= 1'b1;
		repeat (8) @(posedge clk);
		ss_low <= 1'b0;
		rd(CTRL_A_ADDR, d, r);
		`check("host kept", 1'b1, d[CA_HOST])
		$display("test select done");
		wr(CTRL_B_ADDR, 8'h00, r);
		wr(PIN_DIR_ADDR, 8'h0F, r);
		wr(CTRL_A_ADDR, 8'h01, r);
		repeat (3) @(posedge clk);
		`check("role inputs", 4'h0, {mosi_oe, sck_oe, ss_n_oe, miso_oe})
		tx = 8'($urandom);
		rx = 8'($urandom);
		wr(DATA_ADDR, tx, r);
		fork
			peer.host_send(rx, 8, 6);
			begin
				repeat (12) @(posedge clk);
				`check("miso driven", 1'b1, miso_oe)
			end
		join
		wait_done();
		rd(DATA_ADDR, d, r);
		`check("client rx", {24'h0, rx}, d)
		`check("client tx", tx, peer.got)
		peer.host_send(8'hFF, 4, 6);
		rd(FLAGS_ADDR, d, r);
		`check("partial no done", 1'b0, d[FL_DONE])
		rx = 8'($urandom);
		peer.host_send(rx, 8, 6);
		wait_done();
		rd(DATA_ADDR, d, r);
		`check("after partial", {24'h0, rx}, d)
		$display("test client done");
		end_sim();
	end
endmodule : tb_spi_host_client_core
